// ==== rtl/host_port_pkg.sv ====
package host_port_pkg;
   // ==========================================
   // Widths and field positions
   localparam int DATA_W = 32;
   localparam int SEL_W = 6;
   localparam int PTR_W = 8;
   localparam int PTR_LSB = 2;
   localparam int PTR_MSB = 9;
   localparam int GATE_BIT = 0;
   localparam int TRIG_BIT = 0;
   // ==========================================
   // CPU register word indices
   localparam logic [1:0] CPU_POINTER = 2'h0;
   localparam logic [1:0] CPU_TRANSFER = 2'h1;
   localparam logic [1:0] CPU_GATE = 2'h2;
   localparam logic [1:0] CPU_TRIGGER = 2'h3;
   // ==========================================
   // Host register select codes
   localparam logic [5:0] SEL_POINTER = 6'h01;
   localparam logic [5:0] SEL_TRANSFER = 6'h02;
   localparam logic [5:0] SEL_GATE = 6'h03;
   localparam logic [5:0] SEL_RAM = 6'h04;
   // ==========================================
   // Reset values and constants
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [31:0] XFER_RESET = 32'h0000_0000;
   localparam logic [5:0] SEL_RESET = 6'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic [7:0] GATE_KEY = 8'hA5;
   localparam logic [1:0] BANK_MODE_SINGLE = 2'h0;
   // ==========================================
   // Host access phases
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_READ = 2'b01,
      PH_WRITE = 2'b10
   } host_phase_t;
endpackage

// ==== rtl/pin_sync.sv ====
module pin_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] IDLE = '1
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out
);
   // ==========================================
   // Three stages; a change counts once two agree
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } sync_state_t;
   sync_state_t st;
   sync_state_t next_st;
   logic [W-1:0] next_level;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign next_level[i] = (st.s2[i] == st.s3[i]) ? st.s3[i]
                                                       : st.level[i];
      end
   endgenerate
   always_comb begin
      next_st = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.level = next_level;
   end
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= {IDLE, IDLE, IDLE, IDLE};
      end else begin
         st <= next_st;
      end
   end
   assign level_out = st.level;
endmodule // pin_sync

// ==== rtl/dreq_drive.sv ====
module dreq_drive (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic trigger_in,
   input wire logic polarity_in,
   output logic pin_out
);
   // ==========================================
   // Pin level follows the trigger, polarity 1 is active low
   typedef struct packed {
      logic pin;
   } drive_state_t;
   drive_state_t st;
   drive_state_t next_st;
   always_comb begin
      next_st = st;
      next_st.pin = trigger_in ^ polarity_in;
   end
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign pin_out = st.pin;
endmodule // dreq_drive

// ==== rtl/host_port_regs.sv ====
// How it works
// - Pointer keeps word address in bits 9..2
// - Locked access steps pointer by one word
// - CPU reads pointer only, host writes it
// - Transfer word is 32 bits, resets zero
// - CPU may read and write transfer word
// - CPU cannot change the boot gate
// - Gate sets only on key A5; assist reads zero
// - Gate set stalls CPU shared RAM access
// - Gate covers the device-side bank only
// - Gate starts set in host boot mode
// - Gate clear releases CPU to boot
// - CPU writing one asserts DMA request pin (low at polarity 1)
// - Trigger clears when request pin negates
// - CPU writing zero to trigger is ignored
// - Trigger hidden from host; upper bits zero
// - Software waits for trigger clear before set
// - Reserved bits always read zero
// - Select pin low is normal, high index
// - Direction zero increments, one decrements
module host_port_regs
   import host_port_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic host_boot_mode_in,
   input wire logic chip_select_n_in,
   input wire logic read_strobe_n_in,
   input wire logic write_strobe_n_in,
   input wire logic register_select_pin_in,
   input wire logic [host_port_pkg::DATA_W-1:0] host_data_in,
   output logic [host_port_pkg::DATA_W-1:0] host_data_out,
   output logic host_data_oe_n_out,
   input wire logic lock_in,
   input wire logic step_direction_in,
   output logic ram_req_out,
   output logic ram_we_out,
   output logic [host_port_pkg::PTR_W-1:0] ram_word_addr_out,
   output logic [host_port_pkg::DATA_W-1:0] ram_wdata_out,
   input wire logic ram_done_in,
   input wire logic [host_port_pkg::DATA_W-1:0] ram_rdata_in,
   input wire logic cpu_sel_in,
   input wire logic cpu_we_in,
   input wire logic [1:0] cpu_index_in,
   input wire logic [host_port_pkg::DATA_W-1:0] cpu_wdata_in,
   output logic [host_port_pkg::DATA_W-1:0] cpu_rdata_out,
   output logic cpu_ack_out,
   input wire logic cpu_ram_req_in,
   input wire logic cpu_ram_bank_in,
   input wire logic [1:0] bank_mode_bits_in,
   input wire logic bank_select_bit_in,
   output logic cpu_ram_wait_out,
   output logic cpu_boot_run_out,
   input wire logic request_polarity_bit_in,
   input wire logic dma_negate_in,
   output logic dma_request_pin_out
);
   import host_port_pkg::*;

   // ==========================================
   // State
   typedef struct packed {
      host_phase_t phase;
      logic [SEL_W-1:0] index;
      logic [PTR_W-1:0] ptr;
      logic [DATA_W-1:0] xfer;
      logic gate;
      logic strapped;
      logic trigger;
      logic [DATA_W-1:0] hcap;
      logic hrs;
      logic [DATA_W-1:0] hdout;
      logic req;
      logic we;
      logic [DATA_W-1:0] crd;
      logic ack;
   } regs_state_t;
   regs_state_t st;
   regs_state_t next_st;

   // ==========================================
   // Host pin synchronisers
   logic [3:0] pins_s;
   logic cs_n_s;
   logic rd_n_s;
   logic wr_n_s;
   logic rs_s;
   pin_sync #(.W(4), .IDLE(4'hE)) u_sync (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .async_in({chip_select_n_in, read_strobe_n_in,
                 write_strobe_n_in, register_select_pin_in}),
      .level_out(pins_s)
   );
   assign cs_n_s = pins_s[3];
   assign rd_n_s = pins_s[2];
   assign wr_n_s = pins_s[1];
   assign rs_s = pins_s[0];

   logic rd_act;
   logic wr_act;
   logic host_commit;
   logic host_ram_rd;
   logic cpu_write;
   logic dev_bank;
   logic [DATA_W-1:0] host_mux;
   logic [DATA_W-1:0] cpu_mux;
   logic [DATA_W-1:0] ptr_word;

   assign rd_act = !cs_n_s && !rd_n_s;
   assign wr_act = !cs_n_s && !wr_n_s;
   assign host_commit = (st.phase == PH_WRITE) && !wr_act;
   assign host_ram_rd = (st.phase == PH_IDLE) && !wr_act && rd_act
                        && !rs_s && (st.index == SEL_RAM);
   assign cpu_write = cpu_sel_in && cpu_we_in;
   assign ptr_word = {22'h0, st.ptr, 2'h0};

   // ==========================================
   // Read multiplexers
   always_comb begin
      host_mux = '0;
      if (rs_s) begin
         host_mux = {26'h0, st.index};
      end else begin
         case (st.index)
            SEL_POINTER: host_mux = ptr_word;
            SEL_TRANSFER: host_mux = st.xfer;
            SEL_GATE: host_mux = {31'h0, st.gate};
            SEL_RAM: host_mux = st.xfer;
            default: host_mux = '0;
         endcase
      end
   end

   always_comb begin
      cpu_mux = '0;
      case (cpu_index_in)
         CPU_POINTER: cpu_mux = ptr_word;
         CPU_TRANSFER: cpu_mux = st.xfer;
         CPU_GATE: cpu_mux = {31'h0, st.gate};
         CPU_TRIGGER: cpu_mux = {31'h0, st.trigger};
         default: cpu_mux = '0;
      endcase
   end

   // ==========================================
   // Next state
   always_comb begin
      next_st = st;
      next_st.req = 1'b0;
      next_st.ack = cpu_sel_in;
      if (cpu_sel_in) begin
         next_st.crd = cpu_mux;
      end
      // Boot strap is caught on the first edge after reset release
      if (!st.strapped) begin
         next_st.strapped = 1'b1;
         next_st.gate = host_boot_mode_in;
      end
      // CPU side; pointer and gate writes fall through unused
      if (cpu_write && cpu_index_in == CPU_TRANSFER) begin
         next_st.xfer = cpu_wdata_in;
      end
      // Set wins over the negation clear landing the same cycle
      if (cpu_write && cpu_index_in == CPU_TRIGGER
          && cpu_wdata_in[TRIG_BIT]) begin
         next_st.trigger = 1'b1;
      end else if (dma_negate_in) begin
         next_st.trigger = 1'b0;
      end
      // Host access phases
      case (st.phase)
         PH_IDLE: begin
            if (wr_act) begin
               next_st.phase = PH_WRITE;
               next_st.hcap = host_data_in;
               next_st.hrs = rs_s;
            end else if (rd_act) begin
               next_st.phase = PH_READ;
               next_st.hdout = host_mux;
               if (host_ram_rd) begin
                  // Read hands out the held word and refills it
                  next_st.req = 1'b1;
                  next_st.we = 1'b0;
               end
            end
         end
         PH_READ: begin
            if (!rd_act) begin
               next_st.phase = PH_IDLE;
            end
         end
         PH_WRITE: begin
            // Word and select were caught at strobe start; the data pins
            // may already have moved by the time the synced strobe ends
            if (!wr_act) begin
               next_st.phase = PH_IDLE;
            end
         end
         default: begin
            next_st.phase = PH_IDLE;
         end
      endcase
      if (host_commit) begin
         if (st.hrs) begin
            next_st.index = st.hcap[SEL_W-1:0];
         end else begin
            case (st.index)
               SEL_POINTER: begin
                  next_st.ptr = st.hcap[PTR_MSB:PTR_LSB];
               end
               SEL_TRANSFER: begin
                  next_st.xfer = st.hcap;
               end
               SEL_GATE: begin
                  if (st.hcap[7:0] == GATE_KEY) begin
                     next_st.gate = 1'b1;
                  end else if (!st.hcap[GATE_BIT]) begin
                     next_st.gate = 1'b0;
                  end
               end
               SEL_RAM: begin
                  next_st.xfer = st.hcap;
                  next_st.req = 1'b1;
                  next_st.we = 1'b1;
               end
               default: begin
                  next_st.index = st.index;
               end
            endcase
         end
      end
      // RAM completion steps the pointer only under lock
      if (ram_done_in) begin
         if (!st.we) begin
            next_st.xfer = ram_rdata_in;
         end
         if (lock_in) begin
            if (step_direction_in) begin
               next_st.ptr = st.ptr - PTR_STEP;
            end else begin
               next_st.ptr = st.ptr + PTR_STEP;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st.phase <= PH_IDLE;
         st.index <= SEL_RESET;
         st.ptr <= PTR_RESET;
         st.xfer <= XFER_RESET;
         st.gate <= 1'b0;
         st.strapped <= 1'b0;
         st.trigger <= 1'b0;
         st.hcap <= '0;
         st.hrs <= 1'b0;
         st.hdout <= '0;
         st.req <= 1'b0;
         st.we <= 1'b0;
         st.crd <= '0;
         st.ack <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // Outputs
   dreq_drive u_dreq (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .trigger_in(st.trigger),
      .polarity_in(request_polarity_bit_in),
      .pin_out(dma_request_pin_out)
   );

   // Single-bank mode always hands bank 0 to the device side
   assign dev_bank = (bank_mode_bits_in == BANK_MODE_SINGLE)
                     ? 1'b0 : bank_select_bit_in;
   assign cpu_ram_wait_out = cpu_ram_req_in && (st.gate || !st.strapped)
                             && (cpu_ram_bank_in == dev_bank);
   assign cpu_boot_run_out = st.strapped && !st.gate;
   assign host_data_out = st.hdout;
   assign host_data_oe_n_out = (st.phase != PH_READ);
   assign ram_req_out = st.req;
   assign ram_we_out = st.we;
   assign ram_word_addr_out = st.ptr;
   assign ram_wdata_out = st.xfer;
   assign cpu_rdata_out = st.crd;
   assign cpu_ack_out = st.ack;

   // ==========================================
   // Assertions
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   a_ptr_step_up: assert property (
      ram_done_in && lock_in && !step_direction_in && !host_commit
      |=> st.ptr == $past(st.ptr) + PTR_STEP)
      else $error("pointer did not step up");
   a_ptr_step_down: assert property (
      ram_done_in && lock_in && step_direction_in && !host_commit
      |=> st.ptr == $past(st.ptr) - PTR_STEP)
      else $error("pointer did not step down");
   a_ptr_cpu_ro: assert property (
      cpu_write && !host_commit && !ram_done_in |=> $stable(st.ptr))
      else $error("pointer moved without host or ram");
   a_ptr_zero_bits: assert property (
      cpu_sel_in ##1 cpu_ack_out |-> cpu_rdata_out[31:10] == 22'h0
      && cpu_rdata_out[1:0] == 2'h0 || $past(cpu_index_in) != CPU_POINTER)
      else $error("pointer reserved bits set");
   a_xfer_cpu_wr: assert property (
      cpu_write && cpu_index_in == CPU_TRANSFER && !host_commit
      && !ram_done_in |=> st.xfer == $past(cpu_wdata_in))
      else $error("transfer word not written by cpu");
   a_gate_cpu_ro: assert property (
      st.strapped && !host_commit |=> $stable(st.gate))
      else $error("gate changed without host write");
   a_gate_key: assert property (
      host_commit && !st.hrs && st.index == SEL_GATE
      && st.hcap[7:0] == GATE_KEY |=> st.gate ##1 cpu_boot_run_out == 1'b0)
      else $error("gate key write failed");
   a_gate_wait: assert property (
      st.gate && cpu_ram_req_in && cpu_ram_bank_in == dev_bank
      |-> cpu_ram_wait_out)
      else $error("cpu not stalled by gate");
   a_gate_strap: assert property (
      !st.strapped |=> st.strapped && st.gate == $past(host_boot_mode_in))
      else $error("boot strap not caught");
   a_trig_pin: assert property (
      cpu_write && cpu_index_in == CPU_TRIGGER && cpu_wdata_in[0]
      |=> st.trigger ##1 dma_request_pin_out != $past(request_polarity_bit_in))
      else $error("request pin not asserted");
   a_trig_clear: assert property (
      dma_negate_in && !(cpu_write && cpu_index_in == CPU_TRIGGER
      && cpu_wdata_in[0]) |=> !st.trigger)
      else $error("trigger not cleared on negation");
   a_trig_hold: assert property (
      st.trigger && !dma_negate_in |=> st.trigger)
      else $error("trigger cleared by cpu");

   c_host_ptr: cover property (host_commit && st.index == SEL_POINTER);
   c_dma_cycle: cover property (st.trigger ##[1:20] !st.trigger);
   c_boot_go: cover property ($rose(cpu_boot_run_out));
   c_ram_step: cover property (ram_done_in && lock_in);
endmodule // host_port_regs

// ==== testbench/host_model.sv ====
module host_model (
   input wire logic sys_clk_in,
   input wire logic [31:0] bus_in,
   output logic cs_n_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic rs_out,
   output logic drive_out,
   output logic [31:0] data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      rs_out = 1'b0;
      drive_out = 1'b0;
      data_out = '0;
   end
   // ==========================================
   // One strobe cycle; long holds keep the 3-flop sync happy
   task automatic access(input logic rs, input logic we,
         input logic [31:0] wd, output logic [31:0] rd);
      @(negedge sys_clk_in);
      rs_out = rs;
      drive_out = we;
      data_out = wd;
      cs_n_out = 1'b0;
      if (we) begin
         wr_n_out = 1'b0;
      end else begin
         rd_n_out = 1'b0;
      end
      repeat (8) @(posedge sys_clk_in);
      rd = bus_in;
      @(negedge sys_clk_in);
      cs_n_out = 1'b1;
      wr_n_out = 1'b1;
      rd_n_out = 1'b1;
      drive_out = 1'b0;
      repeat (10) @(negedge sys_clk_in);
   endtask
endmodule // host_model

// ==== testbench/host_port_regs_tb.sv ====
module host_port_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import host_port_pkg::*;
   logic sys_clk_in = 1'b0, rst_in = 1'b1, boot = 1'b0;
   logic cs_n, rd_n, wr_n, rs, h_en;
   logic [31:0] h_data, bus, last_bus = '0, dout, rd_v;
   logic oe_n, lock = 1'b0, dir = 1'b0, ram_req, ram_we, ram_done = 1'b0;
   logic [7:0] ram_addr, seen_addr;
   logic [31:0] ram_wdata, seen_wdata, cpu_rdata, cpu_wdata = '0;
   logic cpu_sel = 1'b0, cpu_we = 1'b0, cpu_ack, seen_we;
   logic [1:0] cpu_idx = '0, bmode = '0;
   logic creq = 1'b0, cbank = 1'b0, bank_select_bit = 1'b0, wait_o, run_o;
   logic pol = 1'b0, negate = 1'b0, pin;
   int n_errors = 0, check_count = 0, pend = 0;
   localparam logic [31:0] RAM_WORD = 32'hC3A5_5A3C;
   // Undriven bus shows a changing pattern, never a stale value
   assign bus = h_en ? h_data : (!oe_n ? dout : ~last_bus);
   always @(posedge sys_clk_in) last_bus <= bus;
   initial begin
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   host_model hm (.sys_clk_in(sys_clk_in), .bus_in(bus), .cs_n_out(cs_n),
      .rd_n_out(rd_n), .wr_n_out(wr_n), .rs_out(rs), .drive_out(h_en),
      .data_out(h_data));
   host_port_regs dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .host_boot_mode_in(boot), .chip_select_n_in(cs_n),
      .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
      .register_select_pin_in(rs), .host_data_in(bus),
      .host_data_out(dout), .host_data_oe_n_out(oe_n), .lock_in(lock),
      .step_direction_in(dir), .ram_req_out(ram_req), .ram_we_out(ram_we),
      .ram_word_addr_out(ram_addr), .ram_wdata_out(ram_wdata),
      .ram_done_in(ram_done), .ram_rdata_in(RAM_WORD),
      .cpu_sel_in(cpu_sel), .cpu_we_in(cpu_we), .cpu_index_in(cpu_idx),
      .cpu_wdata_in(cpu_wdata), .cpu_rdata_out(cpu_rdata),
      .cpu_ack_out(cpu_ack), .cpu_ram_req_in(creq),
      .cpu_ram_bank_in(cbank), .bank_mode_bits_in(bmode),
      .bank_select_bit_in(bank_select_bit), .cpu_ram_wait_out(wait_o),
      .cpu_boot_run_out(run_o), .request_polarity_bit_in(pol),
      .dma_negate_in(negate), .dma_request_pin_out(pin));
   // ==========================================
   // Slow RAM answers well after the host strobe ends
   always @(negedge sys_clk_in) begin
      ram_done <= 1'b0;
      if (ram_req === 1'b1) begin
         seen_we <= ram_we;
         seen_addr <= ram_addr;
         seen_wdata <= ram_wdata;
         pend <= 12;
      end else if (pend != 0) begin
         pend <= pend - 1;
         ram_done <= (pend == 1);
      end
   end
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cpu(input logic we, input logic [1:0] idx,
         input logic [31:0] wd, output logic [31:0] rd);
      @(negedge sys_clk_in);
      cpu_sel = 1'b1;
      cpu_we = we;
      cpu_idx = idx;
      cpu_wdata = wd;
      @(negedge sys_clk_in);
      cpu_sel = 1'b0;
      chk("cpu ack", 32'h1, {31'h0, cpu_ack});
      rd = cpu_rdata;
   endtask
   task automatic cpu_rd(input logic [1:0] idx, input logic [31:0] exp,
         input string what);
      logic [31:0] v;
      cpu(1'b0, idx, '0, v);
      chk(what, exp, v);
   endtask
   task automatic host_wr(input logic [5:0] sel, input logic [31:0] d);
      logic [31:0] v;
      hm.access(1'b1, 1'b1, {26'h0, sel}, v);
      hm.access(1'b0, 1'b1, d, v);
   endtask
   task automatic do_reset(input logic b);
      @(negedge sys_clk_in);
      rst_in = 1'b1;
      boot = b;
      repeat (16) @(negedge sys_clk_in);
      rst_in = 1'b0;
      repeat (5) @(negedge sys_clk_in);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset_and_cpu();
      logic [31:0] v;
      cpu_rd(CPU_POINTER, 32'h0, "pointer reset");
      cpu_rd(CPU_TRANSFER, 32'h0, "transfer reset");
      cpu_rd(CPU_GATE, 32'h0, "gate non-host boot");
      cpu_rd(CPU_TRIGGER, 32'h0, "trigger reset");
      cpu(1'b1, CPU_POINTER, 32'hFFFF_FFFF, v);
      cpu_rd(CPU_POINTER, 32'h0, "pointer cpu write");
      cpu(1'b1, CPU_GATE, 32'h0000_00A5, v);
      cpu_rd(CPU_GATE, 32'h0, "gate cpu write");
      cpu(1'b1, CPU_TRANSFER, 32'hF0E1_D2C3, v);
      cpu_rd(CPU_TRANSFER, 32'hF0E1_D2C3, "transfer cpu rw");
   endtask
   task automatic t_pointer();
      host_wr(SEL_POINTER, 32'hFFFF_FFFF);
      cpu_rd(CPU_POINTER, 32'h0000_03FC, "pointer field");
      hm.access(1'b0, 1'b0, '0, rd_v);
      chk("host pointer read", 32'h0000_03FC, rd_v);
      chk("host bus released", 32'h1, {31'h0, oe_n});
      hm.access(1'b1, 1'b0, '0, rd_v);
      chk("host index read", {26'h0, SEL_POINTER}, rd_v);
      host_wr(SEL_TRANSFER, 32'h5A0F_C396);
      cpu_rd(CPU_TRANSFER, 32'h5A0F_C396, "transfer host write");
      cpu(1'b1, CPU_TRANSFER, 32'h0F1E_2D3C, rd_v);
      hm.access(1'b0, 1'b0, '0, rd_v);
      chk("host transfer read", 32'h0F1E_2D3C, rd_v);
   endtask
   task automatic t_gate();
      host_wr(SEL_GATE, 32'h0000_0001);
      cpu_rd(CPU_GATE, 32'h0, "gate without key");
      host_wr(SEL_GATE, 32'h0000_00A5);
      cpu_rd(CPU_GATE, 32'h1, "gate key set");
      creq = 1'b1;
      #1 chk("wait bank0", 32'h1, {31'h0, wait_o});
      cbank = 1'b1;
      #1 chk("wait other bank", 32'h0, {31'h0, wait_o});
      bmode = 2'h1;
      bank_select_bit = 1'b1;
      #1 chk("wait selected bank", 32'h1, {31'h0, wait_o});
      chk("cpu held", 32'h0, {31'h0, run_o});
      host_wr(SEL_GATE, 32'h0);
      chk("wait after clear", 32'h0, {31'h0, wait_o});
      chk("cpu runs", 32'h1, {31'h0, run_o});
      creq = 1'b0;
   endtask
   task automatic t_step();
      lock = 1'b1;
      host_wr(SEL_RAM, 32'h1234_5678);
      // RAM done lands some 17 cycles after the strobe is released
      repeat (12) @(negedge sys_clk_in);
      chk("ram write addr", 32'hFF, {24'h0, seen_addr});
      chk("ram write data", 32'h1234_5678, seen_wdata);
      chk("ram we", 32'h1, {31'h0, seen_we});
      cpu_rd(CPU_POINTER, 32'h0, "pointer plus4 wrap");
      dir = 1'b1;
      hm.access(1'b0, 1'b0, '0, rd_v);
      chk("host ram read", 32'h1234_5678, rd_v);
      repeat (6) @(negedge sys_clk_in);
      chk("ram refill we", 32'h0, {31'h0, seen_we});
      cpu_rd(CPU_TRANSFER, RAM_WORD, "refill word");
      cpu_rd(CPU_POINTER, 32'h0000_03FC, "pointer minus4");
      lock = 1'b0;
      dir = 1'b0;
   endtask
   task automatic t_dma();
      logic [31:0] v;
      cpu(1'b1, CPU_TRIGGER, 32'hFFFF_FFFE, v);
      cpu_rd(CPU_TRIGGER, 32'h0, "trigger zero write");
      chk("pin idle", 32'h0, {31'h0, pin});
      cpu(1'b1, CPU_TRIGGER, 32'h1, v);
      @(negedge sys_clk_in);
      chk("pin raised", 32'h1, {31'h0, pin});
      cpu_rd(CPU_TRIGGER, 32'h1, "trigger set");
      negate = 1'b1;
      @(negedge sys_clk_in);
      negate = 1'b0;
      cpu_rd(CPU_TRIGGER, 32'h0, "trigger cleared");
      chk("pin negated", 32'h0, {31'h0, pin});
      pol = 1'b1;
      repeat (2) @(negedge sys_clk_in);
      chk("pin low active idle", 32'h1, {31'h0, pin});
      pol = 1'b0;
   endtask
   task automatic t_host_boot();
      do_reset(1'b1);
      cpu_rd(CPU_GATE, 32'h1, "gate host boot");
      chk("boot held", 32'h0, {31'h0, run_o});
      host_wr(SEL_GATE, 32'h0);
      chk("boot released", 32'h1, {31'h0, run_o});
   endtask
   task automatic end_sim();
      if (n_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      do_reset(1'b0);
      t_reset_and_cpu();
      t_pointer();
      t_gate();
      t_step();
      t_dma();
      t_host_boot();
      end_sim();
   end
   // Whole run needs about 460 cycles; limit leaves wide margin
   initial begin
      #1000000;
      n_errors++;
      end_sim();
   end
endmodule // host_port_regs_tb
